/* inc/monitor2_pkg.sv */
// Shared constants, field layouts and carriers for the supply monitor 2 control block
package monitor2_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_DETCTL = 8'h0C;
  localparam logic [7:0] OFS_LEVEL  = 8'h10;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] filter_sample_divider;
    logic       filter_disable;
    logic       compare_output_enable;
    logic       response_enable;
    logic       reset_release_select;
    logic       response_select;
  } ctrl0_s;

  typedef struct packed {
    logic       irq_type_select;
    logic [1:0] irq_timing_select;
  } ctrl1_s;

  typedef struct packed {
    logic       detector_enable;
    logic [3:0] threshold_select;
  } analog_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_req_s;

  // ==========================================================================
  // Reset values and bit positions
  localparam ctrl0_s       CTRL0_RST  = 7'h10;
  localparam ctrl1_s       CTRL1_RST  = 3'h0;
  localparam analog_ctrl_s ANALOG_RST = 5'h00;
  localparam int           FLAG_DET_BIT   = 0;
  localparam int           FLAG_LEVEL_BIT = 1;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] TIMING_FALL  = 2'h0;
  localparam logic [1:0] TIMING_RISE  = 2'h1;
  localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
  localparam logic [2:0] HSIZE_WORD   = 3'h2;
  localparam logic [23:0] HADDR_HI_ZERO = 24'h000000;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int RESET_HOLD_NS  = 1000;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_DEPTH   = 3;

  typedef enum logic [1:0] {RST_IDLE, RST_ASSERTED, RST_HOLDING} rst_state_e;

endpackage

/* logic/level_filter.sv */
// Majority-free run filter that follows the comparator only after stable samples
`timescale 1ns/1ps
`default_nettype none
module level_filter
  import monitor2_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic sample_tick,
  input  wire logic level_in,
  output var  logic level_q
);

  logic [FILTER_DEPTH-1:0] hist_q;
  logic [FILTER_DEPTH-1:0] hist_d;

  assign hist_d = {hist_q[FILTER_DEPTH-2:0], level_in};

  // ==========================================================================
  // Sample history, frozen while disabled so no stale edge appears on enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= '1;
    end else if (enable && sample_tick) begin
      hist_q <= hist_d; // RULE18
    end
  end

  // Output moves only on a full run of equal samples
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= 1'b1;
    end else if (enable && sample_tick && ((&hist_d) || !(|hist_d))) begin
      level_q <= level_in; // RULE18
    end
  end

  a_filter_hold_off: assert property (@(posedge clk) disable iff (!reset_n)
    !enable |=> $stable(level_q)) else $error("filter output moved while disabled"); // RULE18
  a_filter_run_ok: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(level_q) |-> $past(level_in) == level_q && $past(hist_q[0]) == level_q)
    else $error("filter output changed without a stable run"); // RULE18

endmodule // level_filter
`default_nettype wire

/* logic/monitor2_ctrl.sv */
// Supply monitor 2 control: AHB-Lite registers, sampling divider, detection and response
// Functional notes
// [RULE1] Four-bit threshold select field drives detector
// [RULE2] Software waits detector settling before configuring
// [RULE3] Filter samples at slow oscillator divided by n
// [RULE4] Filter runs when filter-disable bit is zero
// [RULE5] Software waits 2n+3 slow cycles around filter
// [RULE6] Response select: one reset, zero interrupt
// [RULE7] Software clears detect flag before response enable
// [RULE8] Interrupt or reset only while response enabled
// [RULE9] Compare output enable gates comparator into logic
// [RULE10] Stop: compare off, wait, then response off
// [RULE11] Stop: filter disabled before detector turned off
// [RULE12] Stop: detector enable cleared last
// [RULE13] Unfiltered interrupt start waits two microseconds
// [RULE14] Unfiltered reset start order: select, enable, detector
// [RULE15] Reconfigure only with all enables cleared
// [RULE16] Timing field picks crossing; bit picks NMI
// [RULE17] Flag and response follow selected filtered crossing
// [RULE18] Filter changes after stable run, holds disabled
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module monitor2_ctrl
  import monitor2_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output var  logic [31:0]               hrdata,
  output var  logic                      hreadyout,
  output var  logic                      hresp,
  input  wire logic                      slow_onchip_osc,
  input  wire logic                      cmp_level,
  output var  monitor2_pkg::analog_ctrl_s analog_q,
  output var  logic                      irq_maskable_q,
  output var  logic                      irq_nonmaskable_q,
  output var  logic                      reset_req_q
);

  bus_req_s   req_q;
  ctrl0_s     ctrl0_q;
  ctrl1_s     ctrl1_q;
  logic       detect_flag_q;
  logic       osc_q;
  logic [4:0] div_cnt_q;
  logic [4:0] div_last;
  logic       tick_q;
  logic       filt_level;
  logic       eff_level;
  logic       prev_level_q;
  logic       fall_ev;
  logic       rise_ev;
  logic       sel_ev;
  logic       wr_flags;
  logic       clr_flag;
  logic [31:0] rdata_d;
  rst_state_e state_q;
  rst_state_e state_d;
  logic [7:0] hold_cnt_q;
  localparam logic [7:0] HOLD_LAST = 8'(RESET_HOLD_CYC - 1);

  // ==========================================================================
  // AHB-Lite slave: zero wait states, address phase captured for the data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= hsel && htrans[1] && (hsize == HSIZE_WORD) && (haddr[31:8] == HADDR_HI_ZERO);
      req_q.write <= hwrite;
      req_q.addr  <= haddr[7:0];
    end
  end

  // Always ready and always OKAY; odd-size writes and foreign addresses are ignored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux, sampled at the address phase so hrdata is a flop in the data phase
  always_comb begin
    rdata_d = '0;
    case (haddr[7:0])
      OFS_CTRL0:  rdata_d = {25'h0000000, ctrl0_q};
      OFS_CTRL1:  rdata_d = {29'h00000000, ctrl1_q};
      OFS_FLAGS:  rdata_d = {30'h00000000, eff_level, detect_flag_q};
      OFS_DETCTL: rdata_d = {31'h00000000, analog_q.detector_enable};
      OFS_LEVEL:  rdata_d = {28'h0000000, analog_q.threshold_select};
      default:    rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= (haddr[31:8] == HADDR_HI_ZERO) ? rdata_d : '0;
    end
  end

  // ==========================================================================
  // Configuration registers; sequencing order is left to software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_q  <= CTRL0_RST;
      ctrl1_q  <= CTRL1_RST;
      analog_q <= ANALOG_RST;
    end else if (req_q.valid && req_q.write) begin
      case (req_q.addr)
        OFS_CTRL0:  ctrl0_q <= hwdata[6:0]; // RULE4 RULE6 RULE8 RULE9
        OFS_CTRL1:  ctrl1_q <= hwdata[2:0]; // RULE16
        OFS_DETCTL: analog_q.detector_enable <= hwdata[0];
        OFS_LEVEL:  analog_q.threshold_select <= hwdata[3:0]; // RULE1
        default:    ctrl0_q <= ctrl0_q;
      endcase
    end
  end

  // ==========================================================================
  // Sampling divider on slow oscillator rising edges, n = 2, 4, 8 or 16
  assign div_last = 5'(5'h02 << ctrl0_q.filter_sample_divider) - 5'h01;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q     <= 1'b0;
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      osc_q  <= slow_onchip_osc;
      tick_q <= 1'b0;
      if (slow_onchip_osc && !osc_q) begin
        if (div_cnt_q >= div_last) begin
          div_cnt_q <= '0;
          tick_q    <= 1'b1; // RULE3
        end else begin
          div_cnt_q <= div_cnt_q + 5'h01;
        end
      end
    end
  end

  level_filter u_filter (
    .clk         (clk),
    .reset_n     (reset_n),
    .enable      (!ctrl0_q.filter_disable),
    .sample_tick (tick_q),
    .level_in    (cmp_level),
    .level_q     (filt_level)
  );

  // ==========================================================================
  // Crossing detection; level 0 means supply below threshold
  assign eff_level = ctrl0_q.filter_disable ? cmp_level : filt_level; // RULE4 RULE17
  assign fall_ev   = ctrl0_q.compare_output_enable && prev_level_q && !eff_level; // RULE9
  assign rise_ev   = ctrl0_q.compare_output_enable && !prev_level_q && eff_level; // RULE9

  // Reset mode always watches the fall; interrupt mode follows the timing field
  always_comb begin
    if (ctrl0_q.response_select) begin
      sel_ev = fall_ev; // RULE17
    end else begin
      case (ctrl1_q.irq_timing_select)
        TIMING_FALL: sel_ev = fall_ev; // RULE16
        TIMING_RISE: sel_ev = rise_ev; // RULE16
        default:     sel_ev = fall_ev || rise_ev;
      endcase
    end
  end

  // Tracks even while gated, so enabling comparison never fakes a crossing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_level_q <= 1'b1;
    end else begin
      prev_level_q <= eff_level;
    end
  end

  // ==========================================================================
  // Detect flag: writing 0 clears, writing 1 has no effect, a new event wins
  assign wr_flags = req_q.valid && req_q.write && (req_q.addr == OFS_FLAGS);
  assign clr_flag = wr_flags && !hwdata[FLAG_DET_BIT]; // RULE7

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      detect_flag_q <= 1'b0;
    end else if (sel_ev) begin
      detect_flag_q <= 1'b1; // RULE17
    end else if (clr_flag) begin
      detect_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt pulses, one cycle per crossing, only with response enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_maskable_q    <= 1'b0;
      irq_nonmaskable_q <= 1'b0;
    end else begin
      irq_maskable_q    <= sel_ev && ctrl0_q.response_enable && !ctrl0_q.response_select
                           && !ctrl1_q.irq_type_select; // RULE8 RULE16
      irq_nonmaskable_q <= sel_ev && ctrl0_q.response_enable && !ctrl0_q.response_select
                           && ctrl1_q.irq_type_select; // RULE8 RULE16
    end
  end

  // ==========================================================================
  // Reset request: asserted on a fall, released a hold time after the chosen point
  always_comb begin
    state_d = state_q;
    case (state_q)
      RST_IDLE: begin
        if (sel_ev && ctrl0_q.response_enable && ctrl0_q.response_select) begin
          state_d = RST_ASSERTED; // RULE6 RULE8
        end
      end
      RST_ASSERTED: begin
        if (ctrl0_q.reset_release_select || eff_level) begin
          state_d = RST_HOLDING; // RULE6
        end
      end
      RST_HOLDING: begin
        if (hold_cnt_q == HOLD_LAST) begin
          state_d = RST_IDLE;
        end
      end
      default: state_d = RST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= RST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold counter runs only in the holding state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_q <= '0;
    end else if (state_q == RST_HOLDING) begin
      hold_cnt_q <= hold_cnt_q + 8'h01;
    end else begin
      hold_cnt_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= (state_d != RST_IDLE);
    end
  end

  // ==========================================================================
  // Checks
  a_flag_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    (sel_ev && clr_flag) |=> detect_flag_q) else $error("flag event lost to clear"); // RULE17
  a_flag_needs_cmpe: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(detect_flag_q) |-> $past(ctrl0_q.compare_output_enable)) else $error("flag without compare"); // RULE9
  a_irq_needs_enable: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_maskable_q || irq_nonmaskable_q) |-> $past(ctrl0_q.response_enable) && !$past(ctrl0_q.response_select))
    else $error("interrupt without enable"); // RULE8
  a_irq_type_match: assert property (@(posedge clk) disable iff (!reset_n)
    irq_nonmaskable_q |-> $past(ctrl1_q.irq_type_select) && !irq_maskable_q) else $error("wrong irq type"); // RULE16
  a_reset_mode_only: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_req_q) |-> $past(ctrl0_q.response_select) && $past(ctrl0_q.response_enable))
    else $error("reset outside reset mode"); // RULE6
  a_reset_hold_time: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(reset_req_q) |-> $past(hold_cnt_q) == HOLD_LAST) else $error("reset released early"); // RULE6
  a_tick_spacing: assert property (@(posedge clk) disable iff (!reset_n)
    tick_q |=> !tick_q ##1 !tick_q) else $error("sample ticks too close"); // RULE3
  a_level_drives: assert property (@(posedge clk) disable iff (!reset_n)
    (req_q.valid && req_q.write && req_q.addr == OFS_LEVEL) |=> analog_q.threshold_select == $past(hwdata[3:0]))
    else $error("threshold not written"); // RULE1
  a_bus_okay: assert property (@(posedge clk) disable iff (!reset_n)
    hreadyout && !hresp) else $error("bus not ready or error");

  c_irq_seen:   cover property (@(posedge clk) disable iff (!reset_n) irq_maskable_q);
  c_nmi_seen:   cover property (@(posedge clk) disable iff (!reset_n) irq_nonmaskable_q);
  c_reset_seen: cover property (@(posedge clk) disable iff (!reset_n) $fell(reset_req_q));
  c_flag_clear: cover property (@(posedge clk) disable iff (!reset_n) $fell(detect_flag_q));

endmodule // monitor2_ctrl
`default_nettype wire

/* bench/supply_cmp_model.sv */
// Behavioural supply comparator facing the monitor control block
`timescale 1ns/1ps
`default_nettype none
module supply_cmp_model
  import monitor2_pkg::*;
#(
  parameter int SETTLE_CYC = 40
)(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire monitor2_pkg::analog_ctrl_s analog_q,
  input  wire logic [3:0]                 supply_code,
  output var  logic                       cmp_level
);
  logic [7:0] settle_q;
  logic       junk_q;

  // ==========================================
  // Settling count; a cold comparator gives no trustworthy level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q <= 8'h00;
      junk_q   <= 1'b0;
    end else begin
      junk_q <= ~junk_q;
      if (!analog_q.detector_enable) begin
        settle_q <= 8'h00;
      end else if (settle_q < SETTLE_CYC[7:0]) begin
        settle_q <= settle_q + 8'h01;
      end
    end
  end

  // Above the chosen level reads 1; toggling junk while off or settling
  assign cmp_level = (analog_q.detector_enable && settle_q == SETTLE_CYC[7:0]) ?
                     (supply_code > analog_q.threshold_select) : junk_q;
endmodule // supply_cmp_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the supply monitor 2 control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import monitor2_pkg::*;
  localparam int SETTLE = 40;
  logic         clk, reset_n, hsel, hwrite, hreadyout, hresp, osc, cmp_level;
  logic         irq_m, irq_n, rst_req;
  logic [1:0]   htrans, div_q;
  logic [2:0]   hsize;
  logic [3:0]   supply;
  logic [31:0]  haddr, hwdata, hrdata, rd;
  analog_ctrl_s aq;
  int           err_total, num_checks, m_cnt, n_cnt, cyc, k, n, t;

  // ==========================================
  // Clocks: slow oscillator is the bus clock divided by 8
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) osc <= ~osc;
    if (irq_m === 1'b1) m_cnt <= m_cnt + 1;
    if (irq_n === 1'b1) n_cnt <= n_cnt + 1;
  end

  monitor2_ctrl dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .slow_onchip_osc(osc), .cmp_level(cmp_level),
    .analog_q(aq), .irq_maskable_q(irq_m), .irq_nonmaskable_q(irq_n), .reset_req_q(rst_req));
  supply_cmp_model #(.SETTLE_CYC(SETTLE)) cmp (.clk(clk), .reset_n(reset_n), .analog_q(aq),
    .supply_code(supply), .cmp_level(cmp_level));

  // ==========================================
  // Checks and bus access
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask
  // Held until hready is seen high; waits end only by the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {HADDR_HI_ZERO, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    bus(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask
  task automatic wait_clk(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Counts edges until the reset request shows the wanted level
  task automatic meas_rst(input logic v);
    cyc = 0;
    while (rst_req !== v && cyc < 2000) begin
      @(posedge clk);
      cyc++;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #(8 * 40000);
    err_total++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    {hsel, hwrite, osc, div_q, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    supply = 4'hC;
    {err_total, num_checks, m_cnt, n_cnt} = '0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Reset values and an unmapped word
    rdc(OFS_CTRL0, 32'h10, '1);
    rdc(OFS_CTRL1, 32'h0, '1);
    rdc(OFS_FLAGS, 32'h0, 32'h1);
    chk({27'h0, aq}, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rdc(8'h14, 32'h0, '1);
    wr(OFS_LEVEL, 32'h8);
    wr(OFS_DETCTL, 32'h1);
    // Write lands at the closing edge; look one edge later
    wait_clk(1);
    chk({27'h0, aq}, 32'h18);
    wait_clk(SETTLE + 4);
    // Unfiltered: every timing code, type alternating
    for (k = 0; k < 4; k++) begin
      wr(OFS_CTRL1, {29'h0, k[0], k[1:0]});
      wr(OFS_CTRL0, 32'h18);
      wait_clk(250);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CTRL0, 32'h1C);
      {m_cnt, n_cnt} = '0;
      supply <= 4'h3;
      wait_clk(20);
      supply <= 4'hC;
      wait_clk(20);
      t = (k >= 2) ? 2 : 1;
      chk(m_cnt, k[0] ? 0 : t);
      chk(n_cnt, k[0] ? t : 0);
      rdc(OFS_FLAGS, 32'h3, 32'h3);
      wr(OFS_CTRL0, 32'h10);
    end
    // Flag without response enable, then nothing with compare off
    wr(OFS_CTRL1, 32'h0);
    for (k = 0; k < 2; k++) begin
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CTRL0, k ? 32'h14 : 32'h18);
      {m_cnt, n_cnt} = '0;
      supply <= 4'h3;
      wait_clk(20);
      supply <= 4'hC;
      wait_clk(20);
      rdc(OFS_FLAGS, k ? 32'h0 : 32'h1, 32'h1);
      chk(m_cnt + n_cnt, 32'h0);
    end
    // Reset response, immediate release then level-gated release
    wr(OFS_CTRL0, 32'h13);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_CTRL0, 32'h17);
    wr(OFS_CTRL0, 32'h1F);
    {m_cnt, n_cnt} = '0;
    supply <= 4'h3;
    meas_rst(1'b1);
    chk_rng(cyc, 1, 6);
    meas_rst(1'b0);
    chk_rng(cyc, RESET_HOLD_CYC, RESET_HOLD_CYC + 3);
    supply <= 4'hC;
    wait_clk(20);
    wr(OFS_CTRL0, 32'h1D);
    supply <= 4'h3;
    wait_clk(300);
    chk({31'h0, rst_req}, 32'h1);
    rdc(OFS_FLAGS, 32'h0, 32'h2);
    supply <= 4'hC;
    meas_rst(1'b0);
    chk_rng(cyc, RESET_HOLD_CYC, RESET_HOLD_CYC + 6);
    chk(m_cnt + n_cnt, 32'h0);
    wr(OFS_CTRL0, 32'h10);
    wr(OFS_CTRL1, 32'h0);
    // Filtered starts and stops for every sampling divider
    for (k = 0; k < 4; k++) begin
      n = 2 << k;
      t = 8 * n;
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h10});
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h00});
      wait_clk((2 * n + 3) * 8);
      wr(OFS_FLAGS, 32'h0);
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h04});
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h0C});
      {m_cnt, n_cnt} = '0;
      supply <= 4'h3;
      wait_clk(t);
      supply <= 4'hC;
      wait_clk(4 * t);
      chk(m_cnt, 32'h0);
      supply <= 4'h3;
      cyc = 0;
      while (m_cnt == 0 && cyc < 3000) begin
        @(posedge clk);
        cyc++;
      end
      chk_rng(cyc, 2 * t, 3 * t + 10);
      supply <= 4'hC;
      wait_clk(4 * t);
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h04});
      wait_clk((2 * n + 3) * 8);
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h00});
      wr(OFS_CTRL0, {25'h0, k[1:0], 5'h10});
    end
    wr(OFS_DETCTL, 32'h0);
    wait_clk(1);
    chk({27'h0, aq}, 32'h08);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
